// file: color_prox_measure_sequencer_test.sv
// Purpose: bench for the sequencer
// Assumes: time step shortened to 400 cycles
// Notes: single word transfers only
`timescale 1ns/1ns
module color_prox_measure_sequencer_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, led_sink_output;
    logic [1:0] htrans = 0, led_drive_level;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [15:0] prox_light;
    logic [2:0] hsize = 3'h2;
    logic [15:0] color_light_0 = 16'h0011, color_light_1 = 16'h0022;
    logic [15:0] color_light_2 = 16'h0033, color_light_3 = 16'h0044;
    int failures = 0, check_count = 0, pulses = 0;
    initial forever #20 hclk = ~hclk;
    always @(posedge led_sink_output) pulses++;
    initial begin #400000; failures++; stop_test; end
    cpms_sequencer #(.STEP_CYCLES(400)) u_dut (.hready(hreadyout), .*);
    cpms_led_model u_led (.*);
    // one ahb-lite single transfer, waits on hready in both phases
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk) {hsel, htrans, hwrite, haddr} <= {3'h6, w, 24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        {hsel, htrans, hwdata} <= {3'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic check(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin failures++; $display("[FAIL] %0t got %h", $time, g); end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        xfer(1, cpms_pkg::OFS_DRIVE, 2);
        @(negedge hclk);
        check(led_drive_level, 2);
        xfer(0, cpms_pkg::OFS_DRIVE, 0);
        check(rd, 2);
        xfer(1, cpms_pkg::OFS_PROX_CONV, 32'hFF);
        xfer(1, cpms_pkg::OFS_PULSES, 2);
        xfer(1, cpms_pkg::OFS_ENABLE, 13);
        do xfer(0, cpms_pkg::OFS_STATUS, 0); while (rd[0] !== 1'h1);
        check(pulses, 2);
        xfer(0, cpms_pkg::OFS_PROX_LO, 0);
        check(rd, 32'h3C);
        xfer(0, cpms_pkg::OFS_PROX_HI, 0);
        check(rd, 32'h1);
        xfer(1, cpms_pkg::OFS_ENABLE, 9);
        xfer(0, cpms_pkg::OFS_STATUS, 0);
        check(rd[0], 0);
        xfer(1, cpms_pkg::OFS_ENABLE, 3);
        do xfer(0, cpms_pkg::OFS_STATUS, 0); while (rd[1] !== 1'h1);
        xfer(0, cpms_pkg::OFS_COLOR0, 0);
        check(rd, 32'h11);
        xfer(0, cpms_pkg::OFS_COLOR0 + 8'h0C, 0);
        check(rd, 32'h44);
        stop_test;
    end
endmodule // color_prox_measure_sequencer_test

// file: cpms_led_model.sv
// Purpose: reflecting target in front of the led
// Assumes: fixed background light
// Notes: none
`timescale 1ns/1ns
module cpms_led_model (input wire logic led_sink_output, output logic [15:0] prox_light);
    assign prox_light = led_sink_output ? 16'h0120 : 16'h0020; // echo while lit
endmodule // cpms_led_model

// file: cpms_pkg.sv
// Purpose: shared constants and types for the colour/proximity measurement sequencer
// Assumes: 25 MHz system clock, AHB-Lite register access, 32-bit words
// Notes:   offsets are byte addresses, one aligned word per register
package cpms_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        CPMS_SLEEP      = 3'h0,
        CPMS_START      = 3'h1,
        CPMS_PROX_ACCUM = 3'h2,
        CPMS_PROX_WAIT  = 3'h3,
        CPMS_PROX_ADC   = 3'h4,
        CPMS_WAIT       = 3'h5,
        CPMS_COLOR_INIT = 3'h6,
        CPMS_COLOR_ADC  = 3'h7
    } cpms_state_t;

    // timing
    localparam int CLK_PERIOD_NS    = 40;
    localparam int STEP_TIME_NS     = 2400000;
    localparam int STEP_CYCLES_DEF  = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int LED_ON_NS        = 6300;
    localparam int LED_PERIOD_NS    = 14000;
    localparam int LED_ON_CYCLES    = (LED_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LED_PERIOD_CYC   = (LED_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_EXTEND_MULT = 12;
    localparam int STEP_RANGE       = 256;

    // register byte offsets
    localparam logic [7:0] OFS_ENABLE    = 8'h00;
    localparam logic [7:0] OFS_COLOR_IT  = 8'h04;
    localparam logic [7:0] OFS_WAIT_TIME = 8'h08;
    localparam logic [7:0] OFS_CONFIG    = 8'h0C;
    localparam logic [7:0] OFS_PULSES    = 8'h10;
    localparam logic [7:0] OFS_PROX_CONV = 8'h14;
    localparam logic [7:0] OFS_DRIVE     = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1C;
    localparam logic [7:0] OFS_PROX_LO   = 8'h20;
    localparam logic [7:0] OFS_PROX_HI   = 8'h24;
    localparam logic [7:0] OFS_COLOR0    = 8'h28;

    // enable register fields
    localparam int BIT_POWER_ON = 0;
    localparam int BIT_COLOR_EN = 1;
    localparam int BIT_PROX_EN  = 2;
    localparam int BIT_WAIT_EN  = 3;
    // config register field
    localparam int BIT_WAIT_EXT = 1;
    // status register fields
    localparam int BIT_PROX_VALID  = 0;
    localparam int BIT_COLOR_VALID = 1;
    localparam int POS_STATE       = 4;

    // reset values
    localparam logic [7:0] RST_TIME    = 8'hFF;
    localparam logic [7:0] RST_PULSES  = 8'h01;
    localparam logic [1:0] RST_DRIVE   = 2'h0;

endpackage

// file: cpms_properties.sv
// Purpose: port checks of the sequencer
// Assumes: one clock domain
// Notes: led times counted in 40 ns cycles
`timescale 1ns/1ns
module cpms_checker (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hready,
    input wire logic       hwrite,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // led
    input wire logic       led_sink_output
);
    wire l = led_sink_output;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_on; $rose(l) |-> ##157 l ##1 !l; endproperty
    a_on: assert property (p_on) else $error("led on time");
    property p_of; $fell(l) |-> ##191 !l; endproperty
    a_of: assert property (p_of) else $error("led off time");
    property p_ws; !hreadyout |=> hreadyout; endproperty
    a_ws: assert property (p_ws) else $error("wait too long");
    property p_wr; (hsel && htrans[1] && hready && hwrite) |=> hreadyout; endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_rd; (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout; endproperty
    a_rd: assert property (p_rd) else $error("read wait missing");
    property p_ok; !hresp; endproperty
    a_ok: assert property (p_ok) else $error("error response");
    c_rd: cover property (hsel && htrans[1] && hready && !hwrite);
    c_on: cover property ($rose(l));
    c_of: cover property ($fell(l));
    c_ws: cover property (!hreadyout);
endmodule // cpms_checker
bind cpms_sequencer cpms_checker u_chk (.*);

// file: cpms_sequencer.sv
// Purpose: measurement sequencer for colour integration and pulsed proximity sensing
// Assumes: light levels arrive as synchronous unsigned samples; 25 MHz hclk
// Notes:   AHB-Lite slave, writes zero-wait, reads take one wait state
// Operation
// - power-on reset enters sleep; setting power-on moves to start.
// - power-on control is bit 0 of the register at address 0.
// - from start run proximity, wait, colour in order, only enabled phases.
// - clearing power-on finishes running conversions, then sleeps.
// - four colour channels integrate together; all four counts move at completion.
// - colour results update in one cycle so reads never see partial data.
// - after colour transfer advance to next configured state without host action.
// - colour integration lasts 2.4 ms times (256 minus setting).
// - wait lasts 2.4 ms steps, two's complement count of 1 to 256.
// - LED pulse on 6.3 us within a 14.0 us period.
// - pulse count per accumulation programmable 1 to 255.
// - drive setting selects 100, 50, 25 or 12.5 mA sink current.
// - add light while LED on, subtract background while off, accumulate.
// - convert accumulation to 16-bit result read as two bytes.
// - proximity conversion 1 to 256 steps of 2.4 ms; default 0xFF.
// - proximity-valid set at first proximity completion, held until disabled.
// - drive code 0 highest, 1 is 50, 2 is 25, 3 is 12.5 mA.
// - proximity wait between accumulation and conversion is fixed 2.4 ms.
// - colour init lasts 2.4 ms before colour conversion.
// - wait-extend bit lengthens wait by twelve.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module cpms_sequencer #(
    parameter int STEP_CYCLES = cpms_pkg::STEP_CYCLES_DEF
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // light samples
    input  wire logic [15:0] color_light_0,
    input  wire logic [15:0] color_light_1,
    input  wire logic [15:0] color_light_2,
    input  wire logic [15:0] color_light_3,
    input  wire logic [15:0] prox_light,
    // led driver
    output logic             led_sink_output,
    output logic      [1:0]  led_drive_level
);
    localparam int SCW     = $clog2(STEP_CYCLES + 1);
    localparam int PCW     = $clog2(cpms_pkg::LED_PERIOD_CYC + 1);
    localparam int TW      = 12;
    // background is subtracted over as many off cycles as the led was lit
    localparam int SUB_END = 2 * cpms_pkg::LED_ON_CYCLES;

    // bus side
    logic                  addr_ok;
    logic                  wr_pend_reg;
    logic                  rd_pend_reg;
    logic           [7:0]  addr_reg;
    logic           [31:0] hrdata_reg;
    logic                  hreadyout_reg;
    logic                  hresp_reg;
    logic           [31:0] rd_word;
    // host settings
    logic           [3:0]  enable_reg;
    logic           [7:0]  color_integ_time_reg;
    logic           [7:0]  wait_time_setting_reg;
    logic           [7:0]  prox_pulse_count_reg;
    logic           [7:0]  prox_conv_time_reg;
    logic                  wait_extend_bit_reg;
    logic           [1:0]  led_drive_level_reg;
    logic                  power_on_bit;
    logic                  color_enable;
    logic                  prox_enable;
    logic                  wait_enable;
    // sequencer
    cpms_pkg::cpms_state_t state_reg;
    cpms_pkg::cpms_state_t state_next;
    cpms_pkg::cpms_state_t after_prox;
    cpms_pkg::cpms_state_t after_wait;
    logic                  state_change;
    // step timing
    logic [SCW-1:0]        cyc_cnt_reg;
    logic                  step_tick;
    logic [TW-1:0]         step_cnt_reg;
    logic [TW-1:0]         step_target;
    logic [TW-1:0]         wait_base;
    logic                  phase_end;
    // proximity
    logic [PCW-1:0]        phase_cnt_reg;
    logic [PCW-1:0]        phase_next;
    logic           [7:0]  pulse_cnt_reg;
    logic                  pulse_end;
    logic                  accum_end;
    logic                  led_reg;
    logic signed    [33:0] prox_acc_reg;
    logic           [25:0] prox_pos;
    logic           [8:0]  conv_steps;
    logic           [34:0] prox_prod;
    logic           [15:0] prox_sat;
    logic           [7:0]  prox_lo_reg;
    logic           [7:0]  prox_hi_reg;
    logic                  prox_done;
    logic                  prox_valid_flag_reg;
    // colour
    logic           [15:0] color_in [4];
    logic           [15:0] color_acc_reg [4];
    logic           [15:0] color_res_reg [4];
    logic           [15:0] color_sat [4];
    logic                  color_done;
    logic                  color_valid_reg;

    // every output comes straight from a flop
    assign hrdata          = hrdata_reg;
    assign hreadyout       = hreadyout_reg;
    assign hresp           = hresp_reg;
    assign led_sink_output = led_reg;
    assign led_drive_level = led_drive_level_reg;

    // enable register fields, power-on at bit 0 of offset 0
    assign power_on_bit = enable_reg[cpms_pkg::BIT_POWER_ON];
    assign color_enable = enable_reg[cpms_pkg::BIT_COLOR_EN];
    assign prox_enable  = enable_reg[cpms_pkg::BIT_PROX_EN];
    assign wait_enable  = enable_reg[cpms_pkg::BIT_WAIT_EN];

    // an address phase is taken only while the bus is ready
    assign addr_ok = hsel && htrans[1] && hready;

    // ahb-lite slave: writes land in the data phase, reads insert one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg   <= 1'h0;
            rd_pend_reg   <= 1'h0;
            addr_reg      <= 8'h00;
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'h1;
            hresp_reg     <= 1'h0;
        end else begin
            wr_pend_reg   <= addr_ok && hwrite;
            rd_pend_reg   <= addr_ok && !hwrite;
            hreadyout_reg <= !(addr_ok && !hwrite);
            hresp_reg     <= 1'h0; // always okay
            if (addr_ok) begin
                addr_reg <= haddr[7:0];
            end
            if (rd_pend_reg) begin
                hrdata_reg <= rd_word;
            end
        end
    end

    // host setting registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg            <= 4'h0; // power-on clear: sleep
            color_integ_time_reg  <= cpms_pkg::RST_TIME;
            wait_time_setting_reg <= cpms_pkg::RST_TIME;
            prox_pulse_count_reg  <= cpms_pkg::RST_PULSES;
            prox_conv_time_reg    <= cpms_pkg::RST_TIME;
            wait_extend_bit_reg   <= 1'h0;
            led_drive_level_reg   <= cpms_pkg::RST_DRIVE;
        end else if (wr_pend_reg) begin
            if (addr_reg == cpms_pkg::OFS_ENABLE) begin
                enable_reg <= hwdata[3:0];
            end else if (addr_reg == cpms_pkg::OFS_COLOR_IT) begin
                color_integ_time_reg <= hwdata[7:0];
            end else if (addr_reg == cpms_pkg::OFS_WAIT_TIME) begin
                wait_time_setting_reg <= hwdata[7:0];
            end else if (addr_reg == cpms_pkg::OFS_CONFIG) begin
                wait_extend_bit_reg <= hwdata[cpms_pkg::BIT_WAIT_EXT];
            end else if (addr_reg == cpms_pkg::OFS_PULSES) begin
                prox_pulse_count_reg <= hwdata[7:0];
            end else if (addr_reg == cpms_pkg::OFS_PROX_CONV) begin
                prox_conv_time_reg <= hwdata[7:0];
            end else if (addr_reg == cpms_pkg::OFS_DRIVE) begin
                led_drive_level_reg <= hwdata[1:0];
            end
        end
    end

    // read decode; each colour result is one word, so no colour read sees half an update
    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr_reg == cpms_pkg::OFS_ENABLE) begin
            rd_word = {28'h0, enable_reg};
        end else if (addr_reg == cpms_pkg::OFS_COLOR_IT) begin
            rd_word = {24'h0, color_integ_time_reg};
        end else if (addr_reg == cpms_pkg::OFS_WAIT_TIME) begin
            rd_word = {24'h0, wait_time_setting_reg};
        end else if (addr_reg == cpms_pkg::OFS_CONFIG) begin
            rd_word = {30'h0, wait_extend_bit_reg, 1'h0};
        end else if (addr_reg == cpms_pkg::OFS_PULSES) begin
            rd_word = {24'h0, prox_pulse_count_reg};
        end else if (addr_reg == cpms_pkg::OFS_PROX_CONV) begin
            rd_word = {24'h0, prox_conv_time_reg};
        end else if (addr_reg == cpms_pkg::OFS_DRIVE) begin
            rd_word = {30'h0, led_drive_level_reg};
        end else if (addr_reg == cpms_pkg::OFS_STATUS) begin
            rd_word = {25'h0, state_reg, 2'h0, color_valid_reg, prox_valid_flag_reg};
        end else if (addr_reg == cpms_pkg::OFS_PROX_LO) begin
            rd_word = {24'h0, prox_lo_reg};
        end else if (addr_reg == cpms_pkg::OFS_PROX_HI) begin
            rd_word = {24'h0, prox_hi_reg};
        end else if (addr_reg == cpms_pkg::OFS_COLOR0) begin
            rd_word = {16'h0, color_res_reg[0]};
        end else if (addr_reg == cpms_pkg::OFS_COLOR0 + 8'h04) begin
            rd_word = {16'h0, color_res_reg[1]};
        end else if (addr_reg == cpms_pkg::OFS_COLOR0 + 8'h08) begin
            rd_word = {16'h0, color_res_reg[2]};
        end else if (addr_reg == cpms_pkg::OFS_COLOR0 + 8'h0C) begin
            rd_word = {16'h0, color_res_reg[3]};
        end
    end

    // where to go once a phase is over; disabled phases take no time
    always_comb begin
        if (!power_on_bit) begin
            after_prox = cpms_pkg::CPMS_SLEEP;
        end else if (wait_enable) begin
            after_prox = cpms_pkg::CPMS_WAIT;
        end else if (color_enable) begin
            after_prox = cpms_pkg::CPMS_COLOR_INIT;
        end else begin
            after_prox = cpms_pkg::CPMS_START;
        end
        if (!power_on_bit) begin
            after_wait = cpms_pkg::CPMS_SLEEP;
        end else if (color_enable) begin
            after_wait = cpms_pkg::CPMS_COLOR_INIT;
        end else begin
            after_wait = cpms_pkg::CPMS_START;
        end
    end

    // sequencer next state; a running phase always completes
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cpms_pkg::CPMS_SLEEP: begin
                if (power_on_bit) state_next = cpms_pkg::CPMS_START;
            end
            cpms_pkg::CPMS_START: begin
                if (!power_on_bit) begin
                    state_next = cpms_pkg::CPMS_SLEEP;
                end else if (prox_enable && prox_pulse_count_reg == 8'h00) begin
                    state_next = cpms_pkg::CPMS_PROX_WAIT;
                end else if (prox_enable) begin
                    state_next = cpms_pkg::CPMS_PROX_ACCUM;
                end else begin
                    state_next = after_prox;
                end
            end
            cpms_pkg::CPMS_PROX_ACCUM: begin
                if (accum_end) state_next = cpms_pkg::CPMS_PROX_WAIT;
            end
            cpms_pkg::CPMS_PROX_WAIT: begin
                if (phase_end) state_next = cpms_pkg::CPMS_PROX_ADC;
            end
            cpms_pkg::CPMS_PROX_ADC: begin
                if (phase_end) state_next = after_prox;
            end
            cpms_pkg::CPMS_WAIT: begin
                if (phase_end) state_next = after_wait;
            end
            cpms_pkg::CPMS_COLOR_INIT: begin
                if (phase_end) state_next = cpms_pkg::CPMS_COLOR_ADC;
            end
            cpms_pkg::CPMS_COLOR_ADC: begin
                if (phase_end && power_on_bit) begin
                    state_next = cpms_pkg::CPMS_START;
                end else if (phase_end) begin
                    state_next = cpms_pkg::CPMS_SLEEP;
                end
            end
            default: state_next = cpms_pkg::CPMS_SLEEP;
        endcase
    end

    assign state_change = (state_next != state_reg);

    // sequencer state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= cpms_pkg::CPMS_SLEEP;
        end else begin
            state_reg <= state_next;
        end
    end

    // step length in 2.4 ms units for each timed phase
    always_comb begin
        wait_base   = TW'(cpms_pkg::STEP_RANGE) - {4'h0, wait_time_setting_reg};
        step_target = TW'(1); // prox wait and colour init
        case (state_reg)
            cpms_pkg::CPMS_PROX_ADC: begin
                step_target = TW'(cpms_pkg::STEP_RANGE) - {4'h0, prox_conv_time_reg};
            end
            cpms_pkg::CPMS_WAIT: begin
                step_target = wait_extend_bit_reg ?
                              wait_base * TW'(cpms_pkg::WAIT_EXTEND_MULT) : wait_base;
            end
            cpms_pkg::CPMS_COLOR_ADC: begin
                step_target = TW'(cpms_pkg::STEP_RANGE) - {4'h0, color_integ_time_reg};
            end
            default: step_target = TW'(1);
        endcase
    end

    // step divider, restarted on each state entry so phases last whole steps
    assign step_tick = (cyc_cnt_reg == SCW'(STEP_CYCLES - 1));
    assign phase_end = step_tick && (step_cnt_reg == step_target - TW'(1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_cnt_reg  <= '0;
            step_cnt_reg <= '0;
        end else if (state_change) begin
            cyc_cnt_reg  <= '0;
            step_cnt_reg <= '0;
        end else if (step_tick) begin
            cyc_cnt_reg  <= '0;
            step_cnt_reg <= step_cnt_reg + TW'(1);
        end else begin
            cyc_cnt_reg  <= cyc_cnt_reg + SCW'(1);
        end
    end

    // led pulse train: fixed on time within a fixed period
    assign pulse_end  = (state_reg == cpms_pkg::CPMS_PROX_ACCUM) &&
                        (phase_cnt_reg == PCW'(cpms_pkg::LED_PERIOD_CYC - 1));
    assign accum_end  = pulse_end && (pulse_cnt_reg == prox_pulse_count_reg - 8'h01);
    assign phase_next = (state_reg != cpms_pkg::CPMS_PROX_ACCUM || pulse_end) ?
                        '0 : phase_cnt_reg + PCW'(1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_cnt_reg <= '0;
            pulse_cnt_reg <= 8'h00;
            led_reg       <= 1'h0;
        end else begin
            phase_cnt_reg <= phase_next;
            if (state_reg != cpms_pkg::CPMS_PROX_ACCUM) begin
                pulse_cnt_reg <= 8'h00;
            end else if (pulse_end) begin
                pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
            end
            led_reg <= (state_next == cpms_pkg::CPMS_PROX_ACCUM) &&
                       (phase_next < PCW'(cpms_pkg::LED_ON_CYCLES));
        end
    end

    // scale the net reflected energy by the conversion steps, saturate to 16 bits
    assign prox_pos   = prox_acc_reg[33] ? 26'h0 : prox_acc_reg[33:8];
    assign conv_steps = 9'h100 - {1'h0, prox_conv_time_reg};
    assign prox_prod  = {9'h0, prox_pos} * {26'h0, conv_steps};
    assign prox_sat   = (|prox_prod[34:16]) ? 16'hFFFF : prox_prod[15:0];
    assign prox_done  = (state_reg == cpms_pkg::CPMS_PROX_ADC) && phase_end;

    // add light while lit, take away background while dark
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prox_acc_reg <= 34'sh0;
            prox_lo_reg  <= 8'h00;
            prox_hi_reg  <= 8'h00;
        end else begin
            if (state_reg == cpms_pkg::CPMS_START) begin
                prox_acc_reg <= 34'sh0;
            end else if (led_reg) begin
                prox_acc_reg <= prox_acc_reg + $signed({18'h0, prox_light});
            end else if (state_reg == cpms_pkg::CPMS_PROX_ACCUM &&
                         phase_cnt_reg < PCW'(SUB_END)) begin
                prox_acc_reg <= prox_acc_reg - $signed({18'h0, prox_light});
            end
            if (prox_done) begin
                prox_lo_reg <= prox_sat[7:0];
                prox_hi_reg <= prox_sat[15:8];
            end
        end
    end

    // colour inputs gathered per channel
    assign color_in[0] = color_light_0;
    assign color_in[1] = color_light_1;
    assign color_in[2] = color_light_2;
    assign color_in[3] = color_light_3;
    assign color_done  = (state_reg == cpms_pkg::CPMS_COLOR_ADC) && phase_end;

    // four channels integrate together; results move in one cycle
    for (genvar g = 0; g < 4; g++) begin : g_color
        logic [16:0] sum_w;
        assign sum_w        = {1'h0, color_acc_reg[g]} + {1'h0, color_in[g]};
        assign color_sat[g] = sum_w[16] ? 16'hFFFF : sum_w[15:0];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                color_acc_reg[g] <= 16'h0000;
                color_res_reg[g] <= 16'h0000;
            end else begin
                if (state_reg != cpms_pkg::CPMS_COLOR_ADC) begin
                    color_acc_reg[g] <= 16'h0000;
                end else if (step_tick) begin
                    color_acc_reg[g] <= color_sat[g];
                end
                if (color_done) begin
                    color_res_reg[g] <= color_sat[g];
                end
            end
        end
    end

    // status flags; a completion beats a disable landing in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prox_valid_flag_reg <= 1'h0;
            color_valid_reg     <= 1'h0;
        end else begin
            if (prox_done) begin
                prox_valid_flag_reg <= 1'h1;
            end else if (!prox_enable) begin
                prox_valid_flag_reg <= 1'h0;
            end
            if (color_done) begin
                color_valid_reg <= 1'h1;
            end else if (!color_enable) begin
                color_valid_reg <= 1'h0;
            end
        end
    end
endmodule // cpms_sequencer
